// ### hw/ims_cfg.svh
// timing constants and default sizes for the index motion sequencer
`ifndef IMS_CFG_SVH
`define IMS_CFG_SVH

// ************************************************************
// clock and servo update timing
// ************************************************************
`define IMS_CLK_PERIOD_NS 100
// profile update period, 0.001 s: the resolution of a move duration
`define IMS_SERVO_PERIOD_NS 1000000
`define IMS_SERVO_CYCLES (`IMS_SERVO_PERIOD_NS / `IMS_CLK_PERIOD_NS)

// ************************************************************
// default sizes
// ************************************************************
`define IMS_NUM_MOVES 8
`define IMS_DIST_W 32
`define IMS_SPEED_W 16
`define IMS_TIME_W 16

`endif

// ### hw/ims_pkg.sv
// types shared by the index motion sequencer files
`include "ims_cfg.svh"

package ims_pkg;

	typedef logic [`IMS_DIST_W-1:0] ims_dist_type;
	typedef logic [`IMS_SPEED_W-1:0] ims_speed_type;
	typedef logic [`IMS_TIME_W-1:0] ims_time_type;

	// settings of the move being started, muxed in by the caller
	typedef struct packed {
		ims_dist_type distance;
		ims_speed_type speedLimit;
		ims_speed_type accelRate;
		ims_speed_type decelRate;
		ims_time_type moveDuration;
		logic absolutePos;
		logic registration;
		logic durationModeEnable;
		logic timingReference;
		logic markSourceSelect;
		logic markWindowEnable;
		logic zoneSwitchEnable;
		ims_dist_type postMarkTravel;
		ims_dist_type markWindowBegin;
		ims_dist_type markWindowEnd;
		ims_dist_type zoneOnPoint;
		ims_dist_type zoneOffPoint;
	} ims_move_cfg_type;

	typedef enum logic [2:0] {
		IMS_IDLE = 3'h0,
		IMS_CALC = 3'h1,
		IMS_ACCEL = 3'h3,
		IMS_CRUISE = 3'h2,
		IMS_DECEL = 3'h6,
		IMS_HANDOFF = 3'h7
	} ims_state_type;

	typedef enum logic [1:0] {
		IMS_EXIT_STOP = 2'h0,
		IMS_EXIT_BLEND = 2'h1,
		IMS_EXIT_CHAIN = 2'h2
	} ims_exit_type;

endpackage

// ### hw/ims_divider.sv
// sequential restoring divider used to size the cruise speed of a timed move
`timescale 1ns/1ps
`default_nettype none

module ims_divider import ims_pkg::*; #(
	parameter int WIDTH = 32
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// request
	input wire logic start,
	input wire logic [WIDTH-1:0] dividend,
	input wire logic [WIDTH-1:0] divisor,
	// answer
	output logic done,
	output logic [WIDTH-1:0] quotient
);

	logic [WIDTH-1:0] remReg;
	logic [WIDTH-1:0] divReg;
	logic [WIDTH-1:0] quoReg;
	logic [$clog2(WIDTH+1)-1:0] countReg;
	logic busy;
	logic [WIDTH:0] trial;

	assign trial = {remReg, quoReg[WIDTH-1]} - {1'b0, divReg};

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			remReg <= '0;
			divReg <= '0;
			quoReg <= '0;
			countReg <= '0;
			busy <= 1'b0;
			done <= 1'b0;
		end else begin
			done <= 1'b0;
			if (start) begin
				remReg <= '0;
				divReg <= divisor;
				quoReg <= dividend;
				countReg <= WIDTH[$clog2(WIDTH+1)-1:0];
				busy <= 1'b1;
			end else if (busy) begin
				// one quotient bit per cycle keeps the logic small
				if (!trial[WIDTH]) begin
					remReg <= trial[WIDTH-1:0];
					quoReg <= {quoReg[WIDTH-2:0], 1'b1};
				end else begin
					remReg <= {remReg[WIDTH-2:0], quoReg[WIDTH-1]};
					quoReg <= {quoReg[WIDTH-2:0], 1'b0};
				end
				countReg <= countReg - 1'b1;
				if (countReg == 1) begin
					busy <= 1'b0;
					done <= 1'b1;
				end
			end
		end
	end

	assign quotient = quoReg;

endmodule

`default_nettype wire

// ### hw/ims_sequencer.sv
// index move sequencer: profile generation, move flags, registration, zones
`timescale 1ns/1ps
`default_nettype none
`include "ims_cfg.svh"

// Contract
// - any-done set on normal finish, cleared at start
// - timed move too long sets overrun at start
// - overrun move runs at maximum rates anyway
// - overrun cleared only on clear rising edge
// - accelerating until target speed or decel
// - at-speed holds through pause and master stop
// - at-speed drops when any ramp begins
// - blend decelerates toward next move speed
// - done on ramp end, held until restart
// - running covers the whole profile
// - chained start flows on, program only
// - decelerating until zero or next speed
// - distance incremental, absolute, or registration limit
// - timed move uses milliseconds or master steps
// - move starts on start request rising edge
// - start refused during home, jog, program, stop
// - search exhausted when limit hit without mark
// - zone output between on and off points
// - points are unsigned travel from start
// - travel exactly the offset after a mark
// - window rejects marks outside begin to end
// - homing direction from home speed sign
// - sensor mark captures motor position
module ims_sequencer import ims_pkg::*; #(
	parameter int NUM_MOVES = `IMS_NUM_MOVES,
	parameter int SERVO_CYCLES = `IMS_SERVO_CYCLES
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// start requests and settings of the requested move
	input wire logic [NUM_MOVES-1:0] startReq,
	input wire logic [NUM_MOVES-1:0] blendStart,
	input wire logic [NUM_MOVES-1:0] chainedStart,
	input wire logic fromProgram,
	input wire ims_move_cfg_type moveCfg,
	input wire ims_speed_type blendSpeed,
	input wire logic clearTimedOverrun,
	// interlocks and motion modifiers
	input wire logic homeActive,
	input wire logic jogActive,
	input wire logic programActive,
	input wire logic stopIn,
	input wire logic travelLimit,
	input wire logic motionPause,
	input wire logic masterStep,
	// registration mark sources
	input wire logic markSensorInput,
	input wire ims_speed_type analogLevel,
	input wire ims_speed_type analogThreshold,
	input wire ims_dist_type motorPos,
	// homing
	input wire ims_speed_type homeSpeed,
	output logic homeDirPositive,
	// motion command to the axis
	output ims_speed_type cmdSpeed,
	output logic cmdDirPositive,
	output ims_dist_type cmdPos,
	output ims_dist_type travelled,
	output logic handoff,
	output logic startRefused,
	// per-move status
	output logic [NUM_MOVES-1:0] moveAccel,
	output logic [NUM_MOVES-1:0] moveAtTargetSpeed,
	output logic [NUM_MOVES-1:0] moveDecel,
	output logic [NUM_MOVES-1:0] moveRunning,
	output logic [NUM_MOVES-1:0] moveDone,
	output logic [NUM_MOVES-1:0] markSearchExhausted,
	output logic [NUM_MOVES-1:0] zoneSwitchOut,
	// global status
	output logic anyMoveDone,
	output logic timedProfileOverrun,
	output logic markCaptured,
	output ims_dist_type markPosition
);

	localparam int IW = (NUM_MOVES > 1) ? $clog2(NUM_MOVES) : 1;
	localparam int SW = $clog2(SERVO_CYCLES + 1);

	// ************************************************************
	// start request edge detection and acceptance
	// ************************************************************
	logic [NUM_MOVES-1:0] startPrev;
	logic [NUM_MOVES-1:0] reqAll;
	logic [NUM_MOVES-1:0] startEdge;
	logic clearPrev;
	logic markPrev;
	logic analogPrev;
	logic analogAbove;
	logic interlock;
	logic accept;
	logic [IW-1:0] pickIdx;

	function automatic logic [IW-1:0] firstSet(input logic [NUM_MOVES-1:0] v);
		logic [IW-1:0] r;
		r = '0;
		for (int i = NUM_MOVES - 1; i >= 0; i--) begin
			if (v[i]) begin
				r = i[IW-1:0];
			end
		end
		return r;
	endfunction

	assign reqAll = startReq | blendStart | chainedStart;
	assign startEdge = reqAll & ~startPrev;
	assign pickIdx = firstSet(startEdge);
	// a program may start its own moves while it runs
	assign interlock = homeActive | jogActive | (programActive & ~fromProgram)
		| stopIn | travelLimit;

	ims_state_type state;
	ims_exit_type exitKind;
	logic chainReq;

	assign chainReq = chainedStart[pickIdx] & ~blendStart[pickIdx];
	assign accept = (|startEdge) && !interlock
		&& (state == IMS_IDLE || state == IMS_HANDOFF)
		&& !(chainReq && !fromProgram);
	assign analogAbove = analogLevel >= analogThreshold;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			startPrev <= '0;
			clearPrev <= 1'b0;
			markPrev <= 1'b0;
			analogPrev <= 1'b0;
			startRefused <= 1'b0;
		end else begin
			startPrev <= reqAll;
			clearPrev <= clearTimedOverrun;
			markPrev <= markSensorInput;
			analogPrev <= analogAbove;
			startRefused <= (|startEdge) && !accept;
		end
	end

	// ************************************************************
	// servo tick: real time or master steps
	// ************************************************************
	logic [SW-1:0] tickCount;
	logic msTick;
	ims_move_cfg_type cfg;
	logic advance;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			tickCount <= '0;
			msTick <= 1'b0;
		end else begin
			msTick <= tickCount == SW'(SERVO_CYCLES - 1);
			tickCount <= (tickCount == SW'(SERVO_CYCLES - 1)) ? '0
				: tickCount + 1'b1;
		end
	end

	// a stopped master or a pause freezes the profile, flags stay as they are
	assign advance = (cfg.timingReference ? masterStep : msTick)
		&& !motionPause;

	// ************************************************************
	// timed move sizing
	// ************************************************************
	ims_dist_type magnitude;
	ims_dist_type reqDist;
	logic reqDirPos;
	logic divStart;
	logic divDone;
	ims_dist_type divQuot;

	// absolute target turns into a signed distance from here
	assign reqDist = moveCfg.absolutePos ? moveCfg.distance - cmdPos
		: moveCfg.distance;
	assign reqDirPos = !reqDist[`IMS_DIST_W-1];
	assign divStart = accept && moveCfg.durationModeEnable;

	ims_divider #(
		.WIDTH(`IMS_DIST_W)
	) uDivider (
		.mclk(mclk),
		.rst_n(rst_n),
		.start(divStart),
		.dividend(magnitude + `IMS_DIST_W'(moveCfg.moveDuration) - 1'b1),
		.divisor(`IMS_DIST_W'(moveCfg.moveDuration)),
		.done(divDone),
		.quotient(divQuot)
	);

	assign magnitude = reqDirPos ? reqDist : -reqDist;

	// ************************************************************
	// profile arithmetic
	// ************************************************************
	ims_speed_type cruise;
	ims_speed_type endSpeed;
	ims_dist_type goal;
	ims_dist_type remaining;
	logic aborting;
	logic markSeen;
	logic [IW-1:0] activeIdx;
	logic [63:0] brakeLhs;
	logic [63:0] brakeRhs;
	logic needDecel;
	logic [`IMS_SPEED_W:0] upSpeed;
	ims_speed_type accelNext;
	ims_speed_type decelNext;
	ims_speed_type rampNext;
	ims_dist_type stepRaw;
	ims_dist_type step;
	ims_speed_type effEnd;

	assign remaining = goal - travelled;
	// blending upward needs no braking room beyond the last step
	assign effEnd = (endSpeed > cmdSpeed) ? cmdSpeed : endSpeed;
	assign brakeLhs = 64'(remaining) * 64'(cfg.decelRate) * 64'h2;
	assign brakeRhs = 64'(cmdSpeed) * 64'(cmdSpeed) - 64'(effEnd) * 64'(effEnd)
		+ 64'(cmdSpeed) * 64'(cfg.decelRate);
	assign needDecel = aborting || (exitKind != IMS_EXIT_CHAIN
		&& brakeLhs <= brakeRhs);
	assign upSpeed = {1'b0, cmdSpeed} + {1'b0, cfg.accelRate};
	assign accelNext = (cmdSpeed > cruise)
		? ((cmdSpeed - cruise > cfg.accelRate) ? cmdSpeed - cfg.accelRate
		: cruise)
		: ((upSpeed >= {1'b0, cruise}) ? cruise
		: upSpeed[`IMS_SPEED_W-1:0]);
	assign decelNext = (cmdSpeed > endSpeed)
		? ((cmdSpeed - endSpeed > cfg.decelRate) ? cmdSpeed - cfg.decelRate
		: endSpeed)
		: ((endSpeed - cmdSpeed > cfg.decelRate) ? cmdSpeed + cfg.decelRate
		: endSpeed);
	assign rampNext = (state == IMS_DECEL || needDecel) ? decelNext
		: (state == IMS_ACCEL ? accelNext : cmdSpeed);
	// creep at one unit so a stop ramp still reaches the goal
	assign stepRaw = (rampNext == '0 && !aborting) ? `IMS_DIST_W'(1)
		: `IMS_DIST_W'(rampNext);
	// a late mark can leave too little room; the step clamp ends on the goal
	assign step = (!aborting && stepRaw > remaining) ? remaining : stepRaw;

	// ************************************************************
	// registration mark qualification
	// ************************************************************
	logic markEdge;
	logic inWindow;
	logic markValid;

	assign markEdge = cfg.markSourceSelect ? (analogAbove && !analogPrev)
		: (markSensorInput && !markPrev);
	assign inWindow = !cfg.markWindowEnable
		|| (travelled >= cfg.markWindowBegin
		&& travelled < cfg.markWindowEnd);
	assign markValid = markEdge && inWindow && cfg.registration && !markSeen
		&& !aborting && (state == IMS_ACCEL || state == IMS_CRUISE
		|| state == IMS_DECEL);

	// ************************************************************
	// profile state machine
	// ************************************************************
	logic finish;
	logic finishOk;

	assign finish = advance && (state == IMS_ACCEL || state == IMS_CRUISE
		|| state == IMS_DECEL) && (aborting ? rampNext == '0
		: step == remaining);
	assign finishOk = finish && !aborting;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state <= IMS_IDLE;
			cfg <= '0;
			activeIdx <= '0;
			exitKind <= IMS_EXIT_STOP;
			cruise <= '0;
			endSpeed <= '0;
			goal <= '0;
			aborting <= 1'b0;
			cmdSpeed <= '0;
			cmdDirPositive <= 1'b1;
			cmdPos <= '0;
			travelled <= '0;
			handoff <= 1'b0;
		end else begin
			handoff <= 1'b0;
			if (accept) begin
				cfg <= moveCfg;
				activeIdx <= pickIdx;
				exitKind <= blendStart[pickIdx] ? IMS_EXIT_BLEND
					: (chainReq ? IMS_EXIT_CHAIN : IMS_EXIT_STOP);
				endSpeed <= blendStart[pickIdx] ? blendSpeed : '0;
				goal <= magnitude;
				travelled <= '0;
				aborting <= 1'b0;
				cmdDirPositive <= reqDirPos;
				cruise <= moveCfg.speedLimit;
				// a chained move keeps its speed as the exit speed
				if (chainReq) begin
					endSpeed <= moveCfg.speedLimit;
				end
				state <= moveCfg.durationModeEnable ? IMS_CALC : IMS_ACCEL;
			end else begin
				unique case (state)
				IMS_IDLE, IMS_HANDOFF: begin
				end
				IMS_CALC: begin
					if (divDone) begin
						// an overrun move keeps the maximum speed and runs longer
						if (cfg.moveDuration != '0
							&& divQuot <= `IMS_DIST_W'(cfg.speedLimit)) begin
							cruise <= divQuot[`IMS_SPEED_W-1:0];
						end
						state <= IMS_ACCEL;
					end
				end
				IMS_ACCEL, IMS_CRUISE, IMS_DECEL: begin
					if (stopIn && !aborting) begin
						aborting <= 1'b1;
						endSpeed <= '0;
					end
					if (markValid) begin
						goal <= travelled + cfg.postMarkTravel;
					end
					if (advance) begin
						cmdSpeed <= rampNext;
						travelled <= travelled + step;
						cmdPos <= cmdDirPositive ? cmdPos + step : cmdPos - step;
						if (finish) begin
							if (finishOk && exitKind != IMS_EXIT_STOP) begin
								state <= IMS_HANDOFF;
								handoff <= 1'b1;
							end else begin
								state <= IMS_IDLE;
								cmdSpeed <= '0;
							end
						end else if (needDecel) begin
							state <= IMS_DECEL;
						end else if (state == IMS_ACCEL && accelNext == cruise) begin
							state <= IMS_CRUISE;
						end
					end
				end
				endcase
			end
		end
	end

	// ************************************************************
	// global flags and mark capture
	// ************************************************************
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			timedProfileOverrun <= 1'b0;
		end else if (divDone && state == IMS_CALC
			&& (cfg.moveDuration == '0
			|| divQuot > `IMS_DIST_W'(cfg.speedLimit))) begin
			timedProfileOverrun <= 1'b1;
		end else if (clearTimedOverrun && !clearPrev) begin
			timedProfileOverrun <= 1'b0;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			anyMoveDone <= 1'b0;
		end else if (finishOk) begin
			anyMoveDone <= 1'b1;
		end else if (accept) begin
			anyMoveDone <= 1'b0;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			markSeen <= 1'b0;
			markCaptured <= 1'b0;
			markPosition <= '0;
		end else if (accept) begin
			markSeen <= 1'b0;
			markCaptured <= 1'b0;
		end else if (markValid) begin
			markSeen <= 1'b1;
			markCaptured <= 1'b1;
			markPosition <= motorPos;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			homeDirPositive <= 1'b1;
		end else begin
			homeDirPositive <= !homeSpeed[`IMS_SPEED_W-1];
		end
	end

	// ************************************************************
	// per-move status flags
	// ************************************************************
	for (genvar g = 0; g < NUM_MOVES; g++) begin : gMove
		logic mine;
		logic moving;

		assign mine = activeIdx == IW'(g);
		assign moving = state == IMS_ACCEL || state == IMS_CRUISE
			|| state == IMS_DECEL;

		always_ff @(posedge mclk or negedge rst_n) begin
			if (!rst_n) begin
				moveAccel[g] <= 1'b0;
				moveAtTargetSpeed[g] <= 1'b0;
				moveDecel[g] <= 1'b0;
				moveRunning[g] <= 1'b0;
				zoneSwitchOut[g] <= 1'b0;
			end else begin
				moveAccel[g] <= mine && state == IMS_ACCEL;
				moveAtTargetSpeed[g] <= mine && state == IMS_CRUISE;
				moveDecel[g] <= mine && state == IMS_DECEL;
				moveRunning[g] <= mine && (moving || state == IMS_CALC);
				zoneSwitchOut[g] <= mine && moving && cfg.zoneSwitchEnable
					&& travelled > cfg.zoneOnPoint
					&& travelled < cfg.zoneOffPoint;
			end
		end

		always_ff @(posedge mclk or negedge rst_n) begin
			if (!rst_n) begin
				moveDone[g] <= 1'b0;
				markSearchExhausted[g] <= 1'b0;
			end else if (mine && finishOk) begin
				moveDone[g] <= 1'b1;
				markSearchExhausted[g] <= cfg.registration && !markSeen;
			end else if (accept && pickIdx == IW'(g)) begin
				moveDone[g] <= 1'b0;
				markSearchExhausted[g] <= 1'b0;
			end
		end
	end

endmodule

`default_nettype wire

// ### tb/ims_sequencer_checker.sv
// port assertions for the index move sequencer
`timescale 1ns/1ps
`default_nettype none
module ims_sequencer_checker import ims_pkg::*; #(
	parameter int NUM_MOVES = 8
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// requests and interlocks
	input wire logic [NUM_MOVES-1:0] startReq,
	input wire logic [NUM_MOVES-1:0] blendStart,
	input wire logic [NUM_MOVES-1:0] chainedStart,
	input wire logic clearTimedOverrun,
	input wire logic homeActive,
	input wire logic jogActive,
	input wire logic stopIn,
	input wire logic travelLimit,
	input wire ims_speed_type homeSpeed,
	// status
	input wire logic homeDirPositive,
	input wire logic startRefused,
	input wire logic [NUM_MOVES-1:0] moveAccel,
	input wire logic [NUM_MOVES-1:0] moveAtTargetSpeed,
	input wire logic [NUM_MOVES-1:0] moveDecel,
	input wire logic [NUM_MOVES-1:0] moveRunning,
	input wire logic [NUM_MOVES-1:0] moveDone,
	input wire logic anyMoveDone,
	input wire logic timedProfileOverrun
);
	logic anyReq;
	logic blocked;
	assign anyReq = |(startReq | blendStart | chainedStart);
	// program activity is left out: a program may start its own moves
	assign blocked = homeActive | jogActive | stopIn | travelLimit;
	default clocking @(posedge mclk);
	endclocking
	default disable iff (!rst_n);
	a_done_any: assert property (
		(moveDone & ~$past(moveDone)) != '0 |-> anyMoveDone
	) else $error("move done without any-done");
	a_done_sticky: assert property (
		!(anyReq && !$past(anyReq))
		|=> (moveDone & $past(moveDone)) == $past(moveDone)
	) else $error("done flag dropped without a start");
	a_ramp_excl: assert property (
		(moveAccel & (moveAtTargetSpeed | moveDecel)) == '0
		&& (moveDecel & moveAtTargetSpeed) == '0
	) else $error("ramp flags overlap");
	a_run_cover: assert property (
		((moveAccel | moveAtTargetSpeed | moveDecel) & ~moveRunning) == '0
	) else $error("phase flag outside running");
	a_start_refused: assert property (
		anyReq && !$past(anyReq) && blocked |=> startRefused
	) else $error("blocked start not refused");
	a_overrun_hold: assert property (
		timedProfileOverrun && !$rose(clearTimedOverrun)
		|=> timedProfileOverrun
	) else $error("overrun lost without clear");
	a_overrun_clear: assert property (
		$rose(clearTimedOverrun) && moveRunning == '0
		|=> !timedProfileOverrun
	) else $error("overrun not cleared");
	a_home_dir: assert property (
		1'b1 |=> homeDirPositive == !$past(homeSpeed[15])
	) else $error("homing direction wrong");
endmodule
bind ims_sequencer ims_sequencer_checker #(.NUM_MOVES(NUM_MOVES)) chk_u (
	.mclk(mclk), .rst_n(rst_n), .startReq(startReq),
	.blendStart(blendStart), .chainedStart(chainedStart),
	.clearTimedOverrun(clearTimedOverrun), .homeActive(homeActive),
	.jogActive(jogActive), .stopIn(stopIn), .travelLimit(travelLimit),
	.homeSpeed(homeSpeed), .homeDirPositive(homeDirPositive),
	.startRefused(startRefused), .moveAccel(moveAccel),
	.moveAtTargetSpeed(moveAtTargetSpeed), .moveDecel(moveDecel),
	.moveRunning(moveRunning), .moveDone(moveDone),
	.anyMoveDone(anyMoveDone), .timedProfileOverrun(timedProfileOverrun)
);
`default_nettype wire

// ### tb/ims_axis_model.sv
// servo axis model: follows the command one cycle late, gives marks
`timescale 1ns/1ps
`default_nettype none
module ims_axis_model import ims_pkg::*; (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// command in, feedback out
	input wire ims_dist_type cmdPos,
	output ims_dist_type motorPos,
	output logic markSensorInput
);
	// the position loop lags the command by one clock
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			motorPos <= '0;
		else
			motorPos <= cmdPos;
	end
	// mark strip: one rising edge every 64 units of travel
	assign markSensorInput = motorPos[5];
endmodule
`default_nettype wire

// ### tb/test_index_motion_sequencer.sv
// self-checking bench for the index move sequencer
`timescale 1ns/1ps
`default_nettype none
module test_index_motion_sequencer import ims_pkg::*; ;
	logic mclk, rst_n, fromProgram, clearTimedOverrun, motionPause;
	logic homeActive, jogActive, programActive, stopIn, travelLimit;
	logic homeDirPositive, cmdDirPositive, handoff, startRefused;
	logic anyMoveDone, timedProfileOverrun, markCaptured, markSensorInput;
	logic masterStep = 1'b0;
	logic zoneBad = 1'b0;
	logic [4:0] ilk;
	logic [7:0] startReq, blendStart, chainedStart, moveAccel, moveDecel;
	logic [7:0] moveAtTargetSpeed, moveRunning, moveDone, zoneSwitchOut;
	logic [7:0] markSearchExhausted;
	logic [7:0] seenA = '0, seenV = '0, seenD = '0, seenZ = '0;
	ims_move_cfg_type cfg;
	ims_speed_type blendSpeed, analogThreshold, homeSpeed, cmdSpeed;
	ims_speed_type hoSpeed = '0;
	ims_dist_type motorPos, cmdPos, travelled, markPosition, s;
	int nFail = 0, nChecks = 0, nRef = 0;
	assign {travelLimit, stopIn, programActive, jogActive, homeActive} = ilk;
	ims_sequencer #(.SERVO_CYCLES(4)) dut_u (.mclk(mclk), .rst_n(rst_n),
		.startReq(startReq), .blendStart(blendStart),
		.chainedStart(chainedStart), .fromProgram(fromProgram),
		.moveCfg(cfg), .blendSpeed(blendSpeed),
		.clearTimedOverrun(clearTimedOverrun), .homeActive(homeActive),
		.jogActive(jogActive), .programActive(programActive),
		.stopIn(stopIn), .travelLimit(travelLimit),
		.motionPause(motionPause), .masterStep(masterStep),
		.markSensorInput(markSensorInput), .analogLevel(motorPos[15:0]),
		.analogThreshold(analogThreshold), .motorPos(motorPos),
		.homeSpeed(homeSpeed), .homeDirPositive(homeDirPositive),
		.cmdSpeed(cmdSpeed), .cmdDirPositive(cmdDirPositive),
		.cmdPos(cmdPos), .travelled(travelled), .handoff(handoff),
		.startRefused(startRefused), .moveAccel(moveAccel),
		.moveAtTargetSpeed(moveAtTargetSpeed), .moveDecel(moveDecel),
		.moveRunning(moveRunning), .moveDone(moveDone),
		.markSearchExhausted(markSearchExhausted),
		.zoneSwitchOut(zoneSwitchOut), .anyMoveDone(anyMoveDone),
		.timedProfileOverrun(timedProfileOverrun),
		.markCaptured(markCaptured), .markPosition(markPosition));
	ims_axis_model axis_u (.mclk(mclk), .rst_n(rst_n), .cmdPos(cmdPos),
		.motorPos(motorPos), .markSensorInput(markSensorInput));
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	// free-running master ticks; only moves with timingReference set use them
	always @(negedge mclk) begin
		masterStep <= ~masterStep;
		seenA <= seenA | moveAccel;
		seenV <= seenV | moveAtTargetSpeed;
		seenD <= seenD | moveDecel;
		seenZ <= seenZ | zoneSwitchOut;
		if (handoff === 1'b1)
			hoSpeed <= cmdSpeed;
		if (startRefused === 1'b1)
			nRef <= nRef + 1;
		// one step of slack for the registered output
		if (zoneSwitchOut[0] === 1'b1
			&& (travelled <= 32'hA || travelled >= 32'h24))
			zoneBad <= 1'b1;
	end
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		nChecks++;
		if (seen !== exp) begin
			nFail++;
			$display("[FAIL] t=%0t seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	task automatic go(input int i, input int k);
		@(negedge mclk);
		s = cmdPos;
		if (k == 0)
			startReq[i] = 1'b1;
		else if (k == 1)
			blendStart[i] = 1'b1;
		else
			chainedStart[i] = 1'b1;
		@(negedge mclk);
		startReq = '0;
		blendStart = '0;
		chainedStart = '0;
	endtask
	task automatic fin(input int i);
		int n;
		n = 0;
		repeat (2) @(negedge mclk);
		while (moveRunning[i] === 1'b1 && n < 5000) begin
			@(negedge mclk);
			n++;
		end
		chk(n < 5000, 1'b1);
		@(negedge mclk);
	endtask
	task automatic waitV(input int i);
		for (int n = 0; n < 2000 && moveAtTargetSpeed[i] !== 1'b1; n++)
			@(negedge mclk);
		chk(moveAtTargetSpeed[i], 1'b1);
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", nChecks, nFail);
		if (nFail == 0 && nChecks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		repeat (50000) @(posedge mclk);
		nFail++;
		$display("watchdog expired");
		print_verdict();
	end
	initial begin
		rst_n = 1'b0;
		startReq = '0;
		blendStart = '0;
		chainedStart = '0;
		fromProgram = 1'b0;
		clearTimedOverrun = 1'b0;
		motionPause = 1'b0;
		ilk = '0;
		blendSpeed = 16'h2;
		analogThreshold = '0;
		homeSpeed = 16'h8005;
		cfg = '0;
		cfg.speedLimit = 16'h4;
		cfg.accelRate = 16'h1;
		cfg.decelRate = 16'h1;
		repeat (20) @(negedge mclk);
		rst_n = 1'b1;
		chk({moveRunning, moveDone, markSearchExhausted, zoneSwitchOut}, 0);
		chk({anyMoveDone, timedProfileOverrun, cmdSpeed, cmdPos}, 0);
		cfg.distance = 32'h28;
		cfg.zoneSwitchEnable = 1'b1;
		cfg.zoneOnPoint = 32'hA;
		cfg.zoneOffPoint = 32'h20;
		go(0, 0);
		waitV(0);
		motionPause = 1'b1;
		s = cmdPos;
		repeat (20) @(negedge mclk);
		chk({cmdPos, moveAtTargetSpeed[0]}, {s, 1'b1});
		motionPause = 1'b0;
		fin(0);
		chk({moveDone[0], anyMoveDone, cmdSpeed}, {2'h3, 16'h0});
		chk({homeDirPositive, cmdPos}, {1'b0, 32'h28});
		chk({seenA[0], seenV[0], seenD[0], seenZ[0]}, 4'hF);
		chk({zoneBad, zoneSwitchOut[0]}, 2'h0);
		$display("test plain move done");
		cfg.zoneSwitchEnable = 1'b0;
		cfg.absolutePos = 1'b1;
		cfg.distance = 32'h64;
		go(1, 0);
		repeat (3) @(negedge mclk);
		chk({anyMoveDone, moveDone[0]}, 2'h1);
		fin(1);
		chk({moveDone[1], cmdDirPositive, cmdPos}, {2'h3, 32'h64});
		cfg.absolutePos = 1'b0;
		cfg.registration = 1'b1;
		cfg.distance = 32'h190;
		cfg.markWindowEnable = 1'b1;
		cfg.markWindowBegin = 32'h46;
		cfg.markWindowEnd = 32'hC8;
		cfg.postMarkTravel = 32'h14;
		go(2, 0);
		fin(2);
		chk(markPosition >= 32'hE0 && markPosition < 32'hE4, 1);
		chk(cmdPos, markPosition + 32'h14);
		chk({markCaptured, markSearchExhausted[2]}, 2'h2);
		cfg.markWindowBegin = 32'h12C;
		cfg.markWindowEnd = 32'h190;
		cfg.distance = 32'h28;
		cfg.markSourceSelect = 1'b1;
		analogThreshold = 16'h104;
		go(4, 0);
		fin(4);
		chk({markSearchExhausted[4], moveDone[4]}, 2'h3);
		chk({markCaptured, cmdPos}, {1'b0, s + 32'h28});
		cfg.registration = 1'b0;
		cfg.markWindowEnable = 1'b0;
		$display("test registration done");
		for (int j = 0; j < 6; j++) begin
			ilk = (j < 5) ? 5'(1 << j) : 5'h0;
			go(5, (j < 5) ? 0 : 2);
			repeat (2) @(negedge mclk);
			chk({nRef, moveRunning[5]}, {32'(j + 1), 1'b0});
		end
		homeSpeed = 16'h0005;
		$display("test refusal done");
		ilk = 5'h4;
		fromProgram = 1'b1;
		go(5, 2);
		fin(5);
		chk({hoSpeed, homeDirPositive}, {16'h4, 1'b1});
		go(6, 1);
		fin(6);
		chk({hoSpeed, moveDone[6]}, {16'h2, 1'b1});
		go(7, 0);
		fin(7);
		chk({moveDone[7], cmdSpeed}, {1'b1, 16'h0});
		fromProgram = 1'b0;
		ilk = 5'h0;
		$display("test blend and chain done");
		cfg.distance = 32'h190;
		go(0, 0);
		waitV(0);
		ilk = 5'h8;
		fin(0);
		chk({moveDone[0], anyMoveDone, cmdSpeed}, 0);
		ilk = 5'h0;
		clearTimedOverrun = 1'b1;
		cfg.distance = 32'h28;
		cfg.durationModeEnable = 1'b1;
		cfg.moveDuration = 16'h1;
		go(1, 0);
		repeat (40) @(negedge mclk);
		chk(timedProfileOverrun, 1'b1);
		fin(1);
		chk(cmdPos, s + 32'h28);
		clearTimedOverrun = 1'b0;
		repeat (2) @(negedge mclk);
		chk(timedProfileOverrun, 1'b1);
		clearTimedOverrun = 1'b1;
		repeat (2) @(negedge mclk);
		chk(timedProfileOverrun, 1'b0);
		cfg.timingReference = 1'b1;
		cfg.moveDuration = 16'h14;
		go(2, 0);
		fin(2);
		chk({timedProfileOverrun, cmdPos}, {1'b0, s + 32'h28});
		$display("test stop and timed done");
		print_verdict();
	end
endmodule
`default_nettype wire
